/* core/nvp_pkg.sv */
`default_nettype none
package nvp_pkg;
  // I/O register offsets
  localparam logic [15:0] KEY_OFS     = 16'h00f5;
  localparam logic [15:0] DATA_OFS    = 16'h00f6;
  localparam logic [15:0] BASE_OFS    = 16'h00f7;
  localparam logic [15:0] CTRL_OFS    = 16'h00f8;
  localparam logic [15:0] DIV_OFS     = 16'h00f9;
  localparam logic [15:0] PROT_OFS    = 16'h00fa;
  localparam logic [15:0] PAGE_OFS    = 16'h00fc;
  localparam logic [15:0] ROW_OFS     = 16'h00fd;
  localparam logic [15:0] COL_OFS     = 16'h00fe;
  // Reset values
  localparam logic [7:0]  BASE_RST    = 8'h00;
  localparam logic [7:0]  CTRL_RST    = 8'h88;
  localparam logic [7:0]  DIV_RST     = 8'h01;
  // Field positions and masks
  localparam int          CTRL_EN_BIT = 3;
  localparam int          CTRL_WS_LSB = 5;
  localparam logic [7:0]  BASE_MASK   = 8'hfc;
  localparam logic [7:0]  CTRL_MASK   = 8'he8;
  localparam int          PAGE_INFO_BIT = 7;
  // Unlock key bytes
  localparam logic [7:0]  KEY_FIRST   = 8'hb6;
  localparam logic [7:0]  KEY_SECOND  = 8'h49;
  // Address geometry: 128 pages x 8 rows x 256 columns
  localparam int          PAGE_W      = 7;
  localparam int          ROW_W       = 3;
  localparam int          COL_W       = 8;
  localparam int          ARR_W       = PAGE_W + ROW_W + COL_W;
  // Programming sequencer states
  typedef enum logic [1:0] {
    PS_IDLE = 2'b01,
    PS_BUSY = 2'b10
  } prog_state_e;
endpackage
`default_nettype wire

/* core/nvp_io_port.sv */
// Behaviour
// (R1) Data port write captures byte to program
// (R2) Data port read returns array byte
// (R3) Every data port access advances address
// (R4) Base-high bits 7:2 place 256 KB window
// (R5) Window hit suppresses external chip selects
// (R6) Internal SRAM beats the window
// (R7) Control bit 3 gates memory-space access
// (R8) Control bits 7:5 set wait states
// (R9) Control resets to four waits, enabled
// (R10) Software picks waits meeting access time
// (R11) Divider derives programming clock enable
// (R12) Divider holds 01h-FFh, resets 01h
// (R13) Divider writable only while unlocked
// (R14) Software picks divider per clock rate
// (R15) Unlock needs consecutive B6h then 49h writes
// (R16) Divider or protection write relocks
// (R17) Hold wait while byte programs
// (R18) Increment column, then row, then page
// (R19) Divider counter restarts on rewrite; the code restarts it only when the written value differs from the old one
`default_nettype none
module nvp_io_port (
  input  wire logic        CLK,            // System clock
  input  wire logic        ARST_N,         // Async reset, active low
  input  wire logic [15:0] IO_ADDR,        // I/O address
  input  wire logic        IO_WR,          // I/O write strobe
  input  wire logic        IO_RD,          // I/O read strobe
  input  wire logic [7:0]  IO_WDATA,       // I/O write data
  output logic      [7:0]  IO_RDATA,       // I/O read data, next cycle
  input  wire logic [23:0] MEM_ADDR,       // Memory-space address
  input  wire logic        MEM_REQ,        // Memory cycle start pulse
  input  wire logic        SRAM_HIT,       // Internal SRAM decodes address
  input  wire logic [3:0]  EXT_CS_REQ,     // External selects from decoder
  output logic      [3:0]  EXT_CS,         // Gated external selects
  output logic             NVM_SEL,        // Window selects array
  output logic             WAIT_REQ,       // CPU wait request
  output logic      [17:0] ARR_ADDR,       // Array address for I/O reads
  output logic             ARR_INFO,       // Information page select
  input  wire logic [7:0]  ARR_RDATA,      // Array data at ARR_ADDR
  output logic             ARR_PROG_REQ,   // Program start pulse
  output logic      [17:0] ARR_PROG_ADDR,  // Address being programmed
  output logic             ARR_PROG_INFO,  // Programming info page
  output logic      [7:0]  ARR_PROG_DATA,  // Byte being programmed
  input  wire logic        ARR_PROG_DONE,  // Programming finished pulse
  output logic             PROG_CLK_EN,    // Programming clock enable
  output logic             UNLOCKED        // Key unlock state
);

  logic [7:0]  base_reg, base_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  div_reg, div_next;
  logic [7:0]  page_reg, page_next;
  logic [nvp_pkg::ROW_W-1:0] row_reg, row_next;
  logic [nvp_pkg::COL_W-1:0] col_reg, col_next;
  logic        key_half_reg, key_half_next;
  logic        unl_reg, unl_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [7:0]  dcnt_reg, dcnt_next;
  logic        tick_reg, tick_next;
  logic [2:0]  wcnt_reg, wcnt_next;
  nvp_pkg::prog_state_e ps_reg, ps_next;
  logic [17:0] paddr_reg, paddr_next;
  logic        pinfo_reg, pinfo_next;
  logic [7:0]  pdata_reg, pdata_next;
  logic        preq_reg, preq_next;

  logic        wr_key, wr_data, rd_data, wr_div, wr_prot;
  logic        win_hit, mem_hit;
  logic [2:0]  wait_states;
  logic [17:0] cur_addr;

  // Strobe decode
  assign wr_key  = IO_WR && (IO_ADDR == nvp_pkg::KEY_OFS);
  assign wr_data = IO_WR && (IO_ADDR == nvp_pkg::DATA_OFS);
  assign rd_data = IO_RD && (IO_ADDR == nvp_pkg::DATA_OFS);
  assign wr_div  = IO_WR && (IO_ADDR == nvp_pkg::DIV_OFS);
  assign wr_prot = IO_WR && (IO_ADDR == nvp_pkg::PROT_OFS);
  assign cur_addr = {page_reg[nvp_pkg::PAGE_W-1:0], row_reg, col_reg};
  assign wait_states = ctrl_reg[nvp_pkg::CTRL_WS_LSB +: 3];

  // Window decode; SRAM wins, then the window beats external selects
  assign win_hit = (MEM_ADDR[23:18] == base_reg[7:2])                      // (R4)
                   && ctrl_reg[nvp_pkg::CTRL_EN_BIT];                      // (R7)
  assign mem_hit = win_hit && !SRAM_HIT;                                   // (R6)
  assign NVM_SEL = mem_hit;
  assign EXT_CS  = (win_hit || SRAM_HIT) ? 4'h0 : EXT_CS_REQ;              // (R5)

  // Wait asserted from the request cycle so the CPU never misses it
  assign WAIT_REQ = (ps_reg == nvp_pkg::PS_BUSY)                           // (R17)
                    || (wcnt_reg != 3'h0)
                    || (MEM_REQ && mem_hit && (wait_states != 3'h0));      // (R8)

  // Register file, key sequence and address stepping
  always_comb begin
    base_next     = base_reg;
    ctrl_next     = ctrl_reg;
    div_next      = div_reg;
    page_next     = page_reg;
    row_next      = row_reg;
    col_next      = col_reg;
    key_half_next = key_half_reg;
    unl_next      = unl_reg;
    rdata_next    = rdata_reg;
    if (IO_WR) begin
      // Any other I/O write breaks a half-entered key
      key_half_next = wr_key && (IO_WDATA == nvp_pkg::KEY_FIRST);          // (R15)
      if (wr_key && key_half_reg && (IO_WDATA == nvp_pkg::KEY_SECOND)) begin
        unl_next = 1'b1;                                                   // (R15)
      end
      unique case (IO_ADDR)
        nvp_pkg::BASE_OFS: base_next = IO_WDATA & nvp_pkg::BASE_MASK;      // (R4)
        nvp_pkg::CTRL_OFS: ctrl_next = IO_WDATA & nvp_pkg::CTRL_MASK;      // (R7)
        nvp_pkg::PAGE_OFS: page_next = IO_WDATA;
        nvp_pkg::ROW_OFS:  row_next  = IO_WDATA[nvp_pkg::ROW_W-1:0];
        nvp_pkg::COL_OFS:  col_next  = IO_WDATA;
        default: ;
      endcase
      if (wr_div && unl_reg && (IO_WDATA != 8'h00)) begin
        div_next = IO_WDATA;                                               // (R13) (R12)
      end
      if (wr_div || wr_prot) begin
        unl_next = 1'b0;                                                   // (R16)
      end
    end
    // Step address after each data port access
    if (wr_data || rd_data) begin
      {page_next[nvp_pkg::PAGE_W-1:0], row_next, col_next} =
        cur_addr + 18'h00001;                                              // (R3) (R18)
    end
    if (IO_RD) begin
      unique case (IO_ADDR)
        nvp_pkg::DATA_OFS: rdata_next = ARR_RDATA;                         // (R2)
        nvp_pkg::BASE_OFS: rdata_next = base_reg;
        nvp_pkg::CTRL_OFS: rdata_next = ctrl_reg;
        nvp_pkg::DIV_OFS:  rdata_next = div_reg;
        nvp_pkg::PAGE_OFS: rdata_next = page_reg;
        nvp_pkg::ROW_OFS:  rdata_next = {5'h00, row_reg};
        nvp_pkg::COL_OFS:  rdata_next = col_reg;
        default:           rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      base_reg     <= nvp_pkg::BASE_RST;
      ctrl_reg     <= nvp_pkg::CTRL_RST;                                   // (R9)
      div_reg      <= nvp_pkg::DIV_RST;                                    // (R12)
      page_reg     <= 8'h00;
      row_reg      <= '0;
      col_reg      <= '0;
      key_half_reg <= 1'b0;
      unl_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
    end else begin
      base_reg     <= base_next;
      ctrl_reg     <= ctrl_next;
      div_reg      <= div_next;
      page_reg     <= page_next;
      row_reg      <= row_next;
      col_reg      <= col_next;
      key_half_reg <= key_half_next;
      unl_reg      <= unl_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Programming clock divider, restarted on any accepted rewrite that changes the value
  always_comb begin
    dcnt_next = dcnt_reg + 8'h01;
    tick_next = 1'b0;
    if (div_next != div_reg) begin
      dcnt_next = 8'h00;                                                   // (R19)
    end else if (dcnt_reg + 8'h01 >= div_reg) begin
      dcnt_next = 8'h00;
      tick_next = 1'b1;                                                    // (R11)
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dcnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      dcnt_reg <= dcnt_next;
      tick_reg <= tick_next;
    end
  end

  // Memory-space wait counter; loaded with waits minus the first
  always_comb begin
    wcnt_next = wcnt_reg;
    if (wcnt_reg != 3'h0) begin
      wcnt_next = wcnt_reg - 3'h1;
    end else if (MEM_REQ && mem_hit && (wait_states != 3'h0)) begin
      wcnt_next = wait_states - 3'h1;                                      // (R8)
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wcnt_reg <= 3'h0;
    end else begin
      wcnt_reg <= wcnt_next;
    end
  end

  // Byte programming sequencer; CPU is stalled while busy
  always_comb begin
    ps_next    = ps_reg;
    paddr_next = paddr_reg;
    pinfo_next = pinfo_reg;
    pdata_next = pdata_reg;
    preq_next  = 1'b0;
    unique case (ps_reg)
      nvp_pkg::PS_IDLE: begin
        if (wr_data) begin
          pdata_next = IO_WDATA;                                           // (R1)
          paddr_next = cur_addr;
          pinfo_next = page_reg[nvp_pkg::PAGE_INFO_BIT];
          preq_next  = 1'b1;
          ps_next    = nvp_pkg::PS_BUSY;                                   // (R17)
        end
      end
      nvp_pkg::PS_BUSY: begin
        if (ARR_PROG_DONE && !preq_reg) begin
          ps_next = nvp_pkg::PS_IDLE;                                      // (R17)
        end
      end
      default: ps_next = nvp_pkg::PS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ps_reg    <= nvp_pkg::PS_IDLE;
      paddr_reg <= 18'h00000;
      pinfo_reg <= 1'b0;
      pdata_reg <= 8'h00;
      preq_reg  <= 1'b0;
    end else begin
      ps_reg    <= ps_next;
      paddr_reg <= paddr_next;
      pinfo_reg <= pinfo_next;
      pdata_reg <= pdata_next;
      preq_reg  <= preq_next;
    end
  end

  // Outputs
  assign IO_RDATA      = rdata_reg;
  assign ARR_ADDR      = cur_addr;
  assign ARR_INFO      = page_reg[nvp_pkg::PAGE_INFO_BIT];
  assign ARR_PROG_REQ  = preq_reg;
  assign ARR_PROG_ADDR = paddr_reg;
  assign ARR_PROG_INFO = pinfo_reg;
  assign ARR_PROG_DATA = pdata_reg;
  assign PROG_CLK_EN   = tick_reg;
  assign UNLOCKED      = unl_reg;

endmodule
`default_nettype wire

/* sim/nvp_io_port_monitor.sv */
`default_nettype none
module nvp_io_port_monitor (
  input wire logic        CLK,          // Clock
  input wire logic        ARST_N,       // Reset
  input wire logic [15:0] IO_ADDR,      // I/O addr
  input wire logic        IO_WR,        // Write
  input wire logic        IO_RD,        // Read
  input wire logic [7:0]  IO_WDATA,     // Wdata
  input wire logic [7:0]  IO_RDATA,     // Rdata
  input wire logic [23:0] MEM_ADDR,     // Mem addr
  input wire logic        MEM_REQ,      // Mem start
  input wire logic        SRAM_HIT,     // SRAM hit
  input wire logic [3:0]  EXT_CS_REQ,   // Raw selects
  input wire logic [3:0]  EXT_CS,       // Gated selects
  input wire logic        NVM_SEL,      // Window select
  input wire logic        WAIT_REQ,     // Wait
  input wire logic [17:0] ARR_ADDR,     // Port addr
  input wire logic [7:0]  ARR_RDATA,    // Array byte
  input wire logic        ARR_PROG_REQ, // Prog start
  input wire logic        UNLOCKED      // Key state
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] base_reg;
  logic [7:0] ctrl_reg;
  // Shadow of window registers, updated at the taking edge like the design
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      base_reg <= nvp_pkg::BASE_RST;
      ctrl_reg <= nvp_pkg::CTRL_RST;
    end else if (IO_WR && IO_ADDR == nvp_pkg::BASE_OFS) begin
      base_reg <= IO_WDATA & nvp_pkg::BASE_MASK;
    end else if (IO_WR && IO_ADDR == nvp_pkg::CTRL_OFS) begin
      ctrl_reg <= IO_WDATA & nvp_pkg::CTRL_MASK;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Stall from programming is excluded so only wait states are counted
  sequence hit_start(int w);
    MEM_REQ && NVM_SEL && ctrl_reg[7:5] == w && !$past(WAIT_REQ);
  endsequence
  sequence run4;
    WAIT_REQ [*4] ##1 !WAIT_REQ;
  endsequence
  sequence run7;
    WAIT_REQ [*7] ##1 !WAIT_REQ;
  endsequence
  chk_window_decode: assert property (
    NVM_SEL == (ctrl_reg[3] && MEM_ADDR[23:18] == base_reg[7:2] && !SRAM_HIT))
    else $error("window select wrong");
  chk_cs_gating: assert property (
    EXT_CS == ((NVM_SEL || SRAM_HIT) ? 4'h0 : EXT_CS_REQ)) else $error("external select leak");
  chk_ws_four: assert property (hit_start(4) |-> run4) else $error("four waits wrong");
  chk_ws_seven: assert property (hit_start(7) |-> run7) else $error("seven waits wrong");
  chk_ws_zero: assert property (hit_start(0) |-> !WAIT_REQ) else $error("zero waits wrong");
  chk_data_step: assert property (
    (IO_WR || IO_RD) && IO_ADDR == nvp_pkg::DATA_OFS && !WAIT_REQ
    |=> ARR_ADDR == $past(ARR_ADDR) + 18'h1) else $error("port address not advanced");
  chk_read_data: assert property (
    IO_RD && IO_ADDR == nvp_pkg::DATA_OFS |=> IO_RDATA == $past(ARR_RDATA))
    else $error("port read data wrong");
  chk_prog_start: assert property (
    IO_WR && IO_ADDR == nvp_pkg::DATA_OFS && !WAIT_REQ |=> ARR_PROG_REQ && WAIT_REQ)
    else $error("program not started");
  chk_relock_write: assert property (
    IO_WR && (IO_ADDR == nvp_pkg::DIV_OFS || IO_ADDR == nvp_pkg::PROT_OFS) |=> !UNLOCKED)
    else $error("not relocked");
  chk_unlock_key: assert property (
    $rose(UNLOCKED) |-> $past(IO_WR && IO_ADDR == nvp_pkg::KEY_OFS
    && IO_WDATA == nvp_pkg::KEY_SECOND)) else $error("unlock without key");
endmodule
bind nvp_io_port nvp_io_port_monitor i_mon (
  .CLK(CLK), .ARST_N(ARST_N), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
  .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .MEM_ADDR(MEM_ADDR), .MEM_REQ(MEM_REQ),
  .SRAM_HIT(SRAM_HIT), .EXT_CS_REQ(EXT_CS_REQ), .EXT_CS(EXT_CS), .NVM_SEL(NVM_SEL),
  .WAIT_REQ(WAIT_REQ), .ARR_ADDR(ARR_ADDR), .ARR_RDATA(ARR_RDATA),
  .ARR_PROG_REQ(ARR_PROG_REQ), .UNLOCKED(UNLOCKED)
);
`default_nettype wire

/* sim/nvp_array_model.sv */
`default_nettype none
module nvp_array_model #(
  parameter int PROG_CYC = 6 // Short stand-in for the self-timed program
) (
  input  wire logic        CLK,           // Clock
  input  wire logic        ARST_N,        // Reset
  input  wire logic [17:0] ARR_ADDR,      // Read address
  input  wire logic        ARR_INFO,      // Info page
  output logic      [7:0]  ARR_RDATA,     // Read byte
  input  wire logic        ARR_PROG_REQ,  // Program start
  input  wire logic [17:0] ARR_PROG_ADDR, // Program address
  input  wire logic        ARR_PROG_INFO, // Program info page
  input  wire logic [7:0]  ARR_PROG_DATA, // Program byte
  output logic             ARR_PROG_DONE  // Program done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:524287];
  int         cnt;
  // Array starts erased
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign ARR_RDATA = mem[{ARR_INFO, ARR_ADDR}];
  // Programming only clears bits, like a real cell; done pulses later
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt <= 0;
      ARR_PROG_DONE <= 1'b0;
    end else begin
      ARR_PROG_DONE <= (cnt == 1);
      if (ARR_PROG_REQ) begin
        mem[{ARR_PROG_INFO, ARR_PROG_ADDR}] <= mem[{ARR_PROG_INFO, ARR_PROG_ADDR}] & ARR_PROG_DATA;
        cnt <= PROG_CYC;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb_nvm_io_port_and_clock_divider.sv */
`default_nettype none
module tb_nvm_io_port_and_clock_divider;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, arst_n, io_wr, io_rd, mem_req, sram_hit, nvm_sel, wait_req, info;
  logic        preq, pinfo, pdone, clk_en, unlocked;
  logic [15:0] io_addr;
  logic [7:0]  wdata, rdata, ardata, pdata, rd;
  logic [23:0] mem_addr;
  logic [3:0]  cs_req, ext_cs;
  logic [17:0] arr_addr, paddr, a;
  logic [31:0] seed = 32'h30c5;
  logic [31:0] r;
  int          n_mismatch, total_checks, n;
  logic [7:0]  exp_q [$];
  nvp_io_port i_dut (
    .CLK(clk), .ARST_N(arst_n), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(wdata), .IO_RDATA(rdata), .MEM_ADDR(mem_addr), .MEM_REQ(mem_req),
    .SRAM_HIT(sram_hit), .EXT_CS_REQ(cs_req), .EXT_CS(ext_cs), .NVM_SEL(nvm_sel),
    .WAIT_REQ(wait_req), .ARR_ADDR(arr_addr), .ARR_INFO(info), .ARR_RDATA(ardata),
    .ARR_PROG_REQ(preq), .ARR_PROG_ADDR(paddr), .ARR_PROG_INFO(pinfo),
    .ARR_PROG_DATA(pdata), .ARR_PROG_DONE(pdone), .PROG_CLK_EN(clk_en), .UNLOCKED(unlocked));
  nvp_array_model i_arr (
    .CLK(clk), .ARST_N(arst_n), .ARR_ADDR(arr_addr), .ARR_INFO(info), .ARR_RDATA(ardata),
    .ARR_PROG_REQ(preq), .ARR_PROG_ADDR(paddr), .ARR_PROG_INFO(pinfo),
    .ARR_PROG_DATA(pdata), .ARR_PROG_DONE(pdone));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write, then sit out any programming stall before the next request
  task automatic wr(logic [15:0] ad, logic [7:0] d);
    @(negedge clk);
    io_addr = ad;
    wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    for (int i = 0; i < 50 && wait_req === 1'b1; i++) @(negedge clk);
  endtask
  task automatic rdt(logic [15:0] ad, output logic [7:0] d);
    @(negedge clk);
    io_addr = ad;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = rdata;
  endtask
  // One memory cycle; counts wait cycles including the request cycle
  task automatic mem_cyc(logic [23:0] ad, logic sel, output int w);
    @(negedge clk);
    r = rnd();
    mem_addr = ad;
    cs_req = r[3:0];
    mem_req = 1'b1;
    #1 w = int'(wait_req);
    check("nvm_sel", nvm_sel, sel);
    check("ext_cs", ext_cs, (sel || sram_hit) ? 4'h0 : cs_req);
    @(negedge clk);
    mem_req = 1'b0;
    #1;
    while (wait_req === 1'b1 && w < 20) begin
      w++;
      @(negedge clk);
      #1;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {io_wr, io_rd, mem_req, sram_hit, arst_n} = 5'h0;
    {io_addr, wdata, mem_addr, cs_req} = 52'h0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    rdt(nvp_pkg::CTRL_OFS, rd);
    check("ctrl reset", rd, 8'h88);
    rdt(nvp_pkg::DIV_OFS, rd);
    check("div reset", rd, 8'h01);
    wr(nvp_pkg::BASE_OFS, 8'h17);
    rdt(nvp_pkg::BASE_OFS, rd);
    check("base", rd, 8'h14);
    for (int w = 0; w < 8; w++) begin
      wr(nvp_pkg::CTRL_OFS, {w[2:0], 5'h08});
      mem_cyc({6'h05, r[17:0]}, 1'b1, n);
      check("waits", 24'(n), 24'(w));
    end
    wr(nvp_pkg::CTRL_OFS, 8'h00);
    mem_cyc(24'h140000, 1'b0, n);
    wr(nvp_pkg::CTRL_OFS, 8'h08);
    mem_cyc(24'h180000, 1'b0, n);
    sram_hit = 1'b1;
    mem_cyc(24'h17ffff, 1'b0, n);
    sram_hit = 1'b0;
    // Run across a column and row wrap, first programming then reading back
    for (int k = 0; k < 2; k++) begin
      wr(nvp_pkg::PAGE_OFS, 8'h05);
      wr(nvp_pkg::ROW_OFS, 8'h07);
      wr(nvp_pkg::COL_OFS, 8'hfe);
      a = 18'h2ffe;
      for (int j = 0; j < 3; j++) begin
        r = rnd();
        if (k == 0) exp_q.push_back(r[7:0]);
        if (k == 0) wr(nvp_pkg::DATA_OFS, r[7:0]);
        else rdt(nvp_pkg::DATA_OFS, rd);
        if (k == 1) check("port byte", rd, exp_q.pop_front());
        a = a + 18'h1;
        check("port addr", arr_addr, a);
      end
    end
    wr(nvp_pkg::DIV_OFS, 8'h07);
    rdt(nvp_pkg::DIV_OFS, rd);
    check("locked div", rd, 8'h01);
    wr(nvp_pkg::KEY_OFS, nvp_pkg::KEY_FIRST);
    rdt(nvp_pkg::CTRL_OFS, rd);
    wr(nvp_pkg::KEY_OFS, nvp_pkg::KEY_SECOND);
    check("unlock", unlocked, 1'b1);
    wr(nvp_pkg::DIV_OFS, 8'h33);
    check("relock", unlocked, 1'b0);
    rdt(nvp_pkg::DIV_OFS, rd);
    check("div", rd, 8'h33);
    for (n = 0; n < 300 && clk_en !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    for (n = 1; n < 300 && clk_en !== 1'b1; n++) @(negedge clk);
    check("div period", 24'(n), 24'd51);
    print_verdict();
  end
endmodule
`default_nettype wire
